// ### rxad_regs.sv
// Receive mode and antenna driver control registers with the reception sequencer and driver output logic.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "rxad_consts.svh"

module rxad_regs (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	// Command decoder
	input  wire logic                 cmd_rx_start,
	input  wire logic                 cmd_other,
	// Receive datapath
	input  wire rxad_pkg::rxad_rx_ev_s rx_ev,
	input  wire logic [7:0]           error_flags_register,
	output rxad_pkg::rxad_cfg_s       rx_cfg,
	output rxad_pkg::rxad_rx_ind_s    rx_ind,
	// Antenna drivers
	input  wire logic                 carrier,
	input  wire logic                 tx_envelope,
	output logic                      first_antenna_output,
	output logic                      second_antenna_output
);
	import rxad_pkg::*;

	rxad_state_s st_q;
	rxad_state_s st_d;

	logic       wr_mode;
	logic       wr_drv;
	logic       frame_ok;
	logic       base1;
	logic       base2;
	rxad_cfg_s  cfg_now;

	assign wr_mode  = reg_wr && (reg_addr == `RXAD_ADDR_MODE);
	assign wr_drv   = reg_wr && (reg_addr == `RXAD_ADDR_DRV);
	assign frame_ok = st_q.bit_cnt >= `RXAD_MIN_BITS;

	////////////////////////////////////////////////////////////////////////////
	// Settings as seen by the next reception.
	always_comb begin
		cfg_now.bit_rate     = st_q.mode[`RXAD_M_SPD_HI:`RXAD_M_SPD_LO];
		// Above 106 kBd a cleared enable bit is overridden rather than refused on write.
		cfg_now.crc_check    = st_q.mode[`RXAD_M_CRC] ||
			(cfg_now.bit_rate != `RXAD_SPD_106);
		cfg_now.ignore_short = st_q.mode[`RXAD_M_IGN];
		cfg_now.multi        = st_q.mode[`RXAD_M_MULTI] &&
			(cfg_now.bit_rate != `RXAD_SPD_106);
		cfg_now.frame_format = st_q.mode[`RXAD_M_FRM_HI:`RXAD_M_FRM_LO];
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		st_d                = st_q;
		st_d.ind.cmd_done   = 1'b0;
		st_d.ind.short_drop = 1'b0;
		st_d.ind.fifo_wr    = 1'b0;
		st_d.rdata          = 8'h00;

		if (wr_mode) begin
			st_d.mode = reg_wdata;
		end
		if (wr_drv) begin
			st_d.drv = reg_wdata & `RXAD_DRV_WMASK;
		end
		if (reg_rd) begin
			case (reg_addr)
				`RXAD_ADDR_MODE: st_d.rdata = st_q.mode;
				`RXAD_ADDR_DRV:  st_d.rdata = st_q.drv;
				default:         st_d.rdata = 8'h00;
			endcase
		end

		case (st_q.fsm)
			RXAD_IDLE: begin
				if (cmd_rx_start) begin
					st_d.fsm       = RXAD_RECV;
					st_d.cfg       = cfg_now;
					st_d.bit_cnt   = 3'h0;
					st_d.ind.rx_on = 1'b1;
				end
			end
			RXAD_RECV: begin
				if (rx_ev.bit_valid && !frame_ok) begin
					st_d.bit_cnt = st_q.bit_cnt + 3'h1;
				end
				if (cmd_other || (st_q.cfg.multi && !cfg_now.multi)) begin
					st_d.fsm          = RXAD_IDLE;
					st_d.ind.rx_on    = 1'b0;
					st_d.ind.cmd_done = 1'b1;
				end else if (rx_ev.frame_end) begin
					st_d.bit_cnt = 3'h0;
					if (!frame_ok && st_q.cfg.ignore_short) begin
						st_d.ind.short_drop = 1'b1;
					end else if (st_q.cfg.multi) begin
						st_d.fsm = RXAD_APPEND;
					end else begin
						st_d.fsm          = RXAD_IDLE;
						st_d.ind.rx_on    = 1'b0;
						st_d.ind.cmd_done = 1'b1;
					end
				end
			end
			RXAD_APPEND: begin
				st_d.ind.fifo_wr   = 1'b1;
				st_d.ind.fifo_data = error_flags_register;
				st_d.fsm           = RXAD_RECV;
				// A new frame picks up the latest settings after an appended error byte, but not after a dropped short stream.
				st_d.cfg           = cfg_now;
				if (cmd_other || !cfg_now.multi) begin
					st_d.fsm          = RXAD_IDLE;
					st_d.ind.rx_on    = 1'b0;
					st_d.ind.cmd_done = 1'b1;
				end
			end
			default: begin
				st_d.fsm       = RXAD_IDLE;
				st_d.ind.rx_on = 1'b0;
			end
		endcase

		// The second driver either follows the envelope or sends bare carrier.
		base1 = st_q.drv[`RXAD_D_EN1] && carrier && tx_envelope;
		base2 = st_q.drv[`RXAD_D_EN2] && carrier &&
			(st_q.drv[`RXAD_D_CW2] || tx_envelope);
		st_d.tx1 = base1 ^ (st_q.drv[`RXAD_D_EN1] ?
			st_q.drv[`RXAD_D_INV1_ON] : st_q.drv[`RXAD_D_INV1_OFF]);
		st_d.tx2 = base2 ^ (st_q.drv[`RXAD_D_EN2] ?
			st_q.drv[`RXAD_D_INV2_ON] : st_q.drv[`RXAD_D_INV2_OFF]);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q       <= '0;
			st_q.fsm   <= RXAD_IDLE;
			st_q.mode  <= `RXAD_RST_MODE;
			st_q.drv   <= `RXAD_RST_DRV;
			// Driver two is off with its off-inversion clear, so both outputs idle low.
			st_q.tx1   <= 1'b0;
			st_q.tx2   <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata             = st_q.rdata;
	assign rx_cfg                = st_q.cfg;
	assign rx_ind                = st_q.ind;
	assign first_antenna_output  = st_q.tx1;
	assign second_antenna_output = st_q.tx2;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_crc_forced_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm != RXAD_IDLE && st_q.cfg.bit_rate != `RXAD_SPD_106) |-> st_q.cfg.crc_check)
		else $error("CRC checking off above 106 kBd");

	a_crc_follows_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_IDLE && cmd_rx_start && st_q.mode[`RXAD_M_CRC]) |=> rx_cfg.crc_check)
		else $error("CRC enable not applied at reception start");

	a_rate_latched: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_IDLE && cmd_rx_start) |=>
		rx_cfg.bit_rate == $past(st_q.mode[`RXAD_M_SPD_HI:`RXAD_M_SPD_LO]) &&
		rx_cfg.frame_format == $past(st_q.mode[`RXAD_M_FRM_HI:`RXAD_M_FRM_LO]))
		else $error("Rate or framing not taken at reception start");

	a_cfg_steady: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_RECV && $past(st_q.fsm) == RXAD_RECV) |-> $stable(rx_cfg))
		else $error("Settings changed inside a frame");

	a_short_dropped: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_RECV && rx_ev.frame_end && !cmd_other && !frame_ok &&
		st_q.cfg.ignore_short && !(st_q.cfg.multi && !cfg_now.multi)) |=>
		rx_ind.short_drop && rx_ind.rx_on && !rx_ind.cmd_done)
		else $error("Short stream not dropped silently");

	a_single_stops: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_RECV && rx_ev.frame_end && !st_q.cfg.multi && frame_ok) |=>
		!rx_ind.rx_on && rx_ind.cmd_done ##1 !rx_ind.cmd_done)
		else $error("Receiver not off after single frame");

	a_multi_no_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.cfg.multi && st_q.fsm != RXAD_IDLE && !cmd_other && cfg_now.multi) |=>
		!rx_ind.cmd_done)
		else $error("Multiple reception ended by itself");

	a_err_appended: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_RECV && st_q.cfg.multi && rx_ev.frame_end && frame_ok &&
		!cmd_other && cfg_now.multi) |=> ##1
		(rx_ind.fifo_wr && rx_ind.fifo_data == $past(error_flags_register)))
		else $error("Error byte not appended");

	a_tx1_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
		##1 first_antenna_output == (($past(st_q.drv[`RXAD_D_EN1]) && $past(carrier) &&
		$past(tx_envelope)) ^ ($past(st_q.drv[`RXAD_D_EN1]) ? $past(st_q.drv[`RXAD_D_INV1_ON])
		: $past(st_q.drv[`RXAD_D_INV1_OFF]))))
		else $error("First driver level wrong");

	a_tx2_cw: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.drv[`RXAD_D_EN2] && st_q.drv[`RXAD_D_CW2] && !st_q.drv[`RXAD_D_INV2_ON]) |=>
		second_antenna_output == $past(carrier))
		else $error("Second driver not sending bare carrier");

	a_tx2_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!st_q.drv[`RXAD_D_EN2] |=> second_antenna_output == $past(st_q.drv[`RXAD_D_INV2_OFF]))
		else $error("Second driver off level wrong");

	////////////////////////////////////////////////////////////////////////////
	// Register port checks.
	a_mode_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_mode |=> st_q.mode == $past(reg_wdata))
		else $error("Receive mode write lost");

	a_drv_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_drv |=> st_q.drv == ($past(reg_wdata) & `RXAD_DRV_WMASK))
		else $error("Driver control write lost");

	a_drv_reserved_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.drv & ~`RXAD_DRV_WMASK) == 8'h00)
		else $error("Reserved driver bit set");

	a_mode_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `RXAD_ADDR_MODE) |=> reg_rdata == $past(st_q.mode))
		else $error("Receive mode read wrong");

	a_drv_read_rsvd: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == `RXAD_ADDR_DRV) |=> (reg_rdata & ~`RXAD_DRV_WMASK) == 8'h00)
		else $error("Reserved driver bit read as one");

	a_unmapped_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && reg_addr != `RXAD_ADDR_MODE && reg_addr != `RXAD_ADDR_DRV) |=> reg_rdata == 8'h00)
		else $error("Unmapped read not zero");

	////////////////////////////////////////////////////////////////////////////
	// Reception sequencer checks.
	// The receiver flag must mirror the sequencer exactly, since the datapath gates on it.
	a_rx_on_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_ind.rx_on == (st_q.fsm != RXAD_IDLE))
		else $error("Receiver flag disagrees with sequencer");

	a_start_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_IDLE && cmd_rx_start) |=> rx_ind.rx_on && !rx_ind.cmd_done)
		else $error("Receiver not on after start");

	a_done_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_ind.cmd_done |=> !rx_ind.cmd_done)
		else $error("Command end longer than one cycle");

	a_done_turns_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_ind.cmd_done |-> !rx_ind.rx_on)
		else $error("Command ended with receiver on");

	a_start_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_RECV && cmd_rx_start) |=> $stable(rx_cfg))
		else $error("Start during reception changed settings");

	a_idle_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_IDLE && !cmd_rx_start) |=>
		!rx_ind.rx_on && !rx_ind.short_drop && !rx_ind.fifo_wr)
		else $error("Activity while idle");

	a_other_stops: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm != RXAD_IDLE && cmd_other) |=> !rx_ind.rx_on && rx_ind.cmd_done)
		else $error("Other command did not stop reception");

	a_clear_stops: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_RECV && st_q.cfg.multi && !cfg_now.multi) |=> !rx_ind.rx_on && rx_ind.cmd_done)
		else $error("Cleared multiple bit did not stop reception");

	a_multi_low_rate: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(rx_ind.rx_on && rx_cfg.bit_rate == `RXAD_SPD_106) |-> !rx_cfg.multi)
		else $error("Multiple reception at lowest rate");

	a_crc_out_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(rx_ind.rx_on && rx_cfg.bit_rate != `RXAD_SPD_106) |-> rx_cfg.crc_check)
		else $error("Latched CRC check off above lowest rate");

	a_bit_cnt_sat: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_q.bit_cnt <= `RXAD_MIN_BITS)
		else $error("Bit counter ran past its limit");

	a_drop_keeps_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_ind.short_drop |-> rx_ind.rx_on && !rx_ind.fifo_wr)
		else $error("Dropped stream ended reception");

	a_append_once: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_ind.fifo_wr |=> !rx_ind.fifo_wr)
		else $error("Error byte appended twice");

	a_append_multi: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rx_ind.fifo_wr |-> $past(st_q.cfg.multi))
		else $error("Error byte appended outside multiple reception");

	a_single_no_fifo: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.fsm == RXAD_RECV && !st_q.cfg.multi) |=> !rx_ind.fifo_wr)
		else $error("Error byte appended in single reception");

	////////////////////////////////////////////////////////////////////////////
	// Antenna driver checks.
	a_tx1_mod: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.drv[`RXAD_D_EN1] && !st_q.drv[`RXAD_D_INV1_ON]) |=> first_antenna_output == $past(carrier && tx_envelope))
		else $error("First driver not modulated");

	a_tx1_on_inv: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.drv[`RXAD_D_EN1] && st_q.drv[`RXAD_D_INV1_ON]) |=> first_antenna_output == !$past(carrier && tx_envelope))
		else $error("First driver not inverted while on");

	a_tx1_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!st_q.drv[`RXAD_D_EN1] |=> first_antenna_output == $past(st_q.drv[`RXAD_D_INV1_OFF]))
		else $error("First driver off level wrong");

	a_tx2_mod: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.drv[`RXAD_D_EN2] && !st_q.drv[`RXAD_D_CW2] && !st_q.drv[`RXAD_D_INV2_ON]) |=>
		second_antenna_output == $past(carrier && tx_envelope))
		else $error("Second driver not modulated");

	a_tx2_on_inv: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q.drv[`RXAD_D_EN2] && st_q.drv[`RXAD_D_INV2_ON]) |=>
		second_antenna_output == !$past(carrier && (st_q.drv[`RXAD_D_CW2] || tx_envelope)))
		else $error("Second driver not inverted while on");

endmodule // rxad_regs

// ### rxad_consts.svh
// Register offsets, field positions, reset values and codes of the receive-mode and driver block.
`ifndef RXAD_CONSTS_SVH
`define RXAD_CONSTS_SVH

`define RXAD_ADDR_MODE    8'h13
`define RXAD_ADDR_DRV     8'h14
`define RXAD_RST_MODE     8'h00
`define RXAD_RST_DRV      8'h80
`define RXAD_DRV_WMASK    8'hfb

`define RXAD_M_CRC        7
`define RXAD_M_SPD_HI     6
`define RXAD_M_SPD_LO     4
`define RXAD_M_IGN        3
`define RXAD_M_MULTI      2
`define RXAD_M_FRM_HI     1
`define RXAD_M_FRM_LO     0

`define RXAD_D_INV2_ON    7
`define RXAD_D_INV1_ON    6
`define RXAD_D_INV2_OFF   5
`define RXAD_D_INV1_OFF   4
`define RXAD_D_CW2        3
`define RXAD_D_EN2        1
`define RXAD_D_EN1        0

`define RXAD_SPD_106      3'h0
`define RXAD_SPD_848      3'h3
`define RXAD_FRM_A        2'h0
`define RXAD_FRM_B        2'h3
`define RXAD_MIN_BITS     3'h4

`endif

// ### rxad_pkg.sv
// Types shared by the receive-mode and antenna driver control block.
package rxad_pkg;

	typedef enum logic [1:0] {
		RXAD_IDLE   = 2'b00,
		RXAD_RECV   = 2'b01,
		RXAD_APPEND = 2'b10
	} rxad_fsm_e;

	// Receive settings as applied to the reception in progress.
	typedef struct packed {
		logic       crc_check;
		logic [2:0] bit_rate;
		logic       ignore_short;
		logic       multi;
		logic [1:0] frame_format;
	} rxad_cfg_s;

	// Frame events from the receive datapath.
	typedef struct packed {
		logic bit_valid;
		logic frame_end;
	} rxad_rx_ev_s;

	// Indications towards the datapath and the FIFO.
	typedef struct packed {
		logic       rx_on;
		logic       cmd_done;
		logic       short_drop;
		logic       fifo_wr;
		logic [7:0] fifo_data;
	} rxad_rx_ind_s;

	typedef struct packed {
		rxad_fsm_e    fsm;
		logic [7:0]   mode;
		logic [7:0]   drv;
		logic [7:0]   rdata;
		logic [2:0]   bit_cnt;
		rxad_cfg_s    cfg;
		rxad_rx_ind_s ind;
		logic         tx1;
		logic         tx2;
	} rxad_state_s;

endpackage

// ### rxad_card_model.sv
// Behavioural card that answers with one received stream while the field is on.
`timescale 1ns/1ps
module rxad_card_model (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// Requests from the bench
	input  wire logic             send,
	input  wire logic [2:0]       nbits,
	input  wire logic [1:0]       gap,
	input  wire logic             field,
	// Stream towards the receiver
	output rxad_pkg::rxad_rx_ev_s rx_ev,
	output logic                  busy
);
	import rxad_pkg::*;

	initial begin
		rx_ev = '0;
		busy = 1'b0;
		forever begin
			@(posedge ref_clk);
			// An unpowered card stays silent, so a dead driver shows up as a missing stream.
			if (send && field && !sys_rst) begin
				busy <= 1'b1;
				// Back-to-back bits hold the strobe up, so it is never assigned twice in one step.
				for (int i = 0; i < nbits; i++) begin
					if (gap != 2'd0) begin
						rx_ev.bit_valid <= 1'b0;
						repeat (gap) @(posedge ref_clk);
					end
					rx_ev.bit_valid <= 1'b1;
					@(posedge ref_clk);
				end
				rx_ev.bit_valid <= 1'b0;
				rx_ev.frame_end <= 1'b1;
				@(posedge ref_clk);
				rx_ev.frame_end <= 1'b0;
				busy <= 1'b0;
			end
		end
	end
endmodule // rxad_card_model

// ### test_rx_mode_and_antenna_driver_ctrl.sv
// Self-checking bench of the receive mode and antenna driver registers.
`timescale 1ns/1ps
module test_rx_mode_and_antenna_driver_ctrl;
	import rxad_pkg::*;

	logic         ref_clk, sys_rst, reg_wr, reg_rd, cmd_rx_start, cmd_other;
	logic         carrier, tx_envelope, tx1, tx2, send, busy;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, error_flags_register, fifo_byte;
	logic [2:0]   nbits;
	logic [1:0]   gap;
	rxad_rx_ev_s  rx_ev;
	rxad_cfg_s    rx_cfg;
	rxad_rx_ind_s rx_ind;
	int           bad_count, total_checks, n_done, n_drop, n_fifo;
	// Driver value, carrier, envelope, then expected first and second outputs.
	localparam logic [11:0] rows [10] = '{12'h01e, 12'h018, 12'h41c, 12'h10e, 12'h20d,
		12'h02d, 12'h82c, 12'h0a9, 12'h028, 12'h0a0};

	rxad_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_rx_start(cmd_rx_start),
		.cmd_other(cmd_other), .rx_ev(rx_ev), .error_flags_register(error_flags_register), .rx_cfg(rx_cfg),
		.rx_ind(rx_ind), .carrier(carrier), .tx_envelope(tx_envelope), .first_antenna_output(tx1),
		.second_antenna_output(tx2));
	rxad_card_model card (.ref_clk(ref_clk), .sys_rst(sys_rst), .send(send), .nbits(nbits), .gap(gap),
		.field(tx1), .rx_ev(rx_ev), .busy(busy));

	always #12.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		if (rx_ind.cmd_done === 1'b1)
			n_done++;
		if (rx_ind.short_drop === 1'b1)
			n_drop++;
		if (rx_ind.fifo_wr === 1'b1) begin
			n_fifo++;
			fifo_byte = rx_ind.fifo_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s: got %h, expected %h", $time, what, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, what);
	endtask

	// A value of ff skips the settings check where the latched form is left open.
	task start_rx(input logic [7:0] cfg);
		@(posedge ref_clk);
		cmd_rx_start <= 1'b1;
		@(posedge ref_clk);
		cmd_rx_start <= 1'b0;
		#1 chk({7'h0, rx_ind.rx_on}, 8'h01, "receiver on");
		if (cfg !== 8'hff)
			chk(rx_cfg, cfg, "latched settings");
	endtask

	task frame(input logic [2:0] n);
		int k;
		@(posedge ref_clk);
		send <= 1'b1;
		nbits <= n;
		@(posedge ref_clk);
		send <= 1'b0;
		for (k = 0; k < 200; k++) begin
			@(posedge ref_clk);
			if (busy !== 1'b1)
				break;
		end
		if (k == 200) begin
			bad_count++;
			$display("MISMATCH %0t card stream hung", $time);
			tally_and_finish;
		end
		repeat (3) @(posedge ref_clk);
	endtask

	task stop_check(input string what);
		repeat (2) @(posedge ref_clk);
		#1 chk({7'h0, rx_ind.rx_on}, 8'h00, what);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		{reg_wr, reg_rd, cmd_rx_start, cmd_other, send, carrier, tx_envelope} = '0;
		{reg_addr, reg_wdata, nbits, gap} = '0;
		error_flags_register = 8'h5a;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			wr(8'h14, rows[i][11:4]);
			carrier <= rows[i][3];
			tx_envelope <= rows[i][2];
			repeat (2) @(posedge ref_clk);
			#1 chk({6'h0, tx1, tx2}, {6'h0, rows[i][1:0]}, "driver levels");
		end
		$display("driver table done");
		wr(8'h14, 8'hff);
		rd(8'h14, 8'hfb, "reserved driver bit");
		wr(8'h15, 8'h77);
		rd(8'h15, 8'h00, "unmapped read");
		wr(8'h13, 8'hff);
		rd(8'h13, 8'hff, "mode read back");
		$display("register access done");
		wr(8'h14, 8'h01);
		carrier <= 1'b1;
		tx_envelope <= 1'b1;
		wr(8'h13, 8'h83);
		start_rx(8'h83);
		frame(3'd4);
		stop_check("single frame stop");
		wr(8'h13, 8'h08);
		start_rx(8'h08);
		wr(8'h13, 8'h83);
		#1 chk(rx_cfg, 8'h08, "settings held in reception");
		frame(3'd2);
		chk({n_drop[6:0], rx_ind.rx_on}, 8'h03, "short stream dropped");
		frame(3'd4);
		chk(n_done[7:0], 8'h02, "frame after short stream");
		$display("single reception done");
		wr(8'h13, 8'h94);
		start_rx(8'h94);
		frame(3'd4);
		error_flags_register <= 8'ha5;
		gap <= 2'd2;
		frame(3'd5);
		chk({n_done[3:0], n_fifo[2:0], rx_ind.rx_on}, 8'h25, "multi frames");
		chk(fifo_byte, 8'ha5, "appended error byte");
		@(posedge ref_clk);
		cmd_other <= 1'b1;
		@(posedge ref_clk);
		cmd_other <= 1'b0;
		stop_check("stop by other command");
		start_rx(8'h94);
		wr(8'h13, 8'h90);
		stop_check("stop by cleared bit");
		$display("multiple reception done");
		wr(8'h13, 8'h04);
		start_rx(8'hff);
		frame(3'd4);
		stop_check("multi ignored at lowest rate");
		wr(8'h13, 8'h30);
		start_rx(8'hb0);
		$display("rate limits done");
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1 chk({5'h0, rx_ind.rx_on, tx1, tx2}, 8'h00, "outputs after reset");
		rd(8'h13, 8'h00, "mode reset value");
		rd(8'h14, 8'h80, "driver reset value");
		$display("mid-run reset done");
		tally_and_finish;
	end
endmodule // test_rx_mode_and_antenna_driver_ctrl
